// *** core/rpmm_pkg.sv ***
// shared constants and types of the rpm threshold monitor
package rpmm_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int GATE_MS = 1000;
   localparam int GATE_CYC = GATE_MS * (CLK_HZ / 1000);
   localparam int DEB_MS = 10;
   localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);
   localparam int MS_PER_MIN = 60_000;
   localparam int RPM_SCALE = MS_PER_MIN / GATE_MS;
   // ------------------------------------------------------------
   // values
   // ------------------------------------------------------------
   localparam logic [15:0] UPPER_RST = 16'h01F4;
   localparam logic [15:0] LOWER_RST = 16'h00C8;
   localparam logic [15:0] STEP_RPM = 16'h0064;
   localparam logic [15:0] RPM_MAX = 16'h270F;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RPM = 8'h04;
   localparam logic [7:0] REG_MIN = 8'h08;
   localparam logic [7:0] REG_MAX = 8'h0C;
   localparam logic [7:0] REG_UPPER = 8'h10;
   localparam logic [7:0] REG_LOWER = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // key bit positions
   // ------------------------------------------------------------
   localparam int K_DOWN = 0;
   localparam int K_UP = 1;
   localparam int K_LEFT = 2;
   localparam int K_RIGHT = 3;
   localparam int K_CENTER = 4;
   localparam int K_MAX = 5;
   localparam int K_MIN = 6;
   localparam int N_KEYS = 7;
   typedef struct packed {
      logic min_recall_key;
      logic max_recall_key;
      logic nav_center;
      logic nav_right;
      logic nav_left;
      logic nav_up;
      logic nav_down;
   } rpmm_keys_t;
   typedef struct packed {
      logic over_alarm_lamp;
      logic in_band_lamp;
      logic under_alarm_lamp;
   } rpmm_lamps_t;
   typedef enum logic [1:0] {ST_MEAS, ST_SET_LO, ST_SET_HI} rpmm_mode_t;
endpackage : rpmm_pkg

// *** core/rpmm_top.sv ***
// rpm threshold monitor: pulse counting, lamps, keys, display, AXI4-Lite registers
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module rpmm_top #(
   parameter int MAGNETS = 1,
   parameter int GATE_CYCLES = rpmm_pkg::GATE_CYC,
   parameter int DEB_CYCLES = rpmm_pkg::DEB_CYC
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   // sensor and keys (asynchronous pins)
   input wire logic MAG_PULSE_I,
   input wire rpmm_pkg::rpmm_keys_t KEYS_I,
   // lamps and display
   output rpmm_pkg::rpmm_lamps_t LAMPS_O,
   output logic [15:0] DISP_BCD_O,
   output logic DISP_ON_O,
   // AXI4-Lite write
   input wire logic [7:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   // AXI4-Lite read
   input wire logic [7:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I
);
   import rpmm_pkg::*;

   function automatic logic [15:0] to_bcd(input logic [15:0] v);
      logic [31:0] s;
      s = {16'h0000, v};
      for (int i = 0; i < 16; i++) begin
         for (int d = 0; d < 4; d++) begin
            if (s[16 + 4 * d +: 4] >= 4'h5) begin
               s[16 + 4 * d +: 4] = s[16 + 4 * d +: 4] + 4'h3;
            end
         end
         s = {s[30:0], 1'b0};
      end
      return s[31:16];
   endfunction : to_bcd

   // ------------------------------------------------------------
   // synchronisers and debounce
   // ------------------------------------------------------------
   logic [N_KEYS:0] sync1, sync2;
   logic [N_KEYS-1:0] deb, deb_d, press;
   logic mag_d;

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         sync1 <= '0;
         sync2 <= '0;
         mag_d <= 1'b0;
         deb_d <= '0;
      end else begin
         sync1 <= {MAG_PULSE_I, KEYS_I};
         sync2 <= sync1;
         mag_d <= sync2[N_KEYS];
         deb_d <= deb;
      end
   end

   for (genvar k = 0; k < N_KEYS; k++) begin : g_deb
      logic [31:0] cnt;
      // a level must stay put for the whole window before it counts
      always_ff @(posedge CLOCK_I) begin
         if (!NRST_I) begin
            cnt <= '0;
            deb[k] <= 1'b0;
         end else if (sync2[k] == deb[k]) begin
            cnt <= '0;
         end else if (cnt >= 32'(DEB_CYCLES - 1)) begin
            cnt <= '0;
            deb[k] <= sync2[k];
         end else begin
            cnt <= cnt + 32'h1;
         end
      end
   end
   assign press = deb & ~deb_d;

   // ------------------------------------------------------------
   // speed measurement
   // ------------------------------------------------------------
   logic [31:0] gate_cnt;
   logic [15:0] pulses, rpm;
   logic rpm_stb;
   logic [31:0] prod;
   assign prod = ({16'h0000, pulses} * 32'(RPM_SCALE)) / 32'(MAGNETS);

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         gate_cnt <= '0;
         pulses <= '0;
         rpm <= '0;
         rpm_stb <= 1'b0;
      end else begin
         rpm_stb <= 1'b0;
         if (gate_cnt >= 32'(GATE_CYCLES - 1)) begin
            gate_cnt <= '0;
            pulses <= {15'h0000, sync2[N_KEYS] & ~mag_d};
            rpm <= (prod > {16'h0000, RPM_MAX}) ? RPM_MAX : prod[15:0];
            rpm_stb <= 1'b1;
         end else begin
            gate_cnt <= gate_cnt + 32'h1;
            if (sync2[N_KEYS] && !mag_d && pulses != 16'hFFFF) begin
               pulses <= pulses + 16'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // link state, thresholds, min and max
   // ------------------------------------------------------------
   logic online, online_d, link_rise;
   logic [15:0] upper, lower, min_rpm, max_rpm;
   rpmm_mode_t mode;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   assign link_rise = online && !online_d;

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         online_d <= 1'b0;
      end else begin
         online_d <= online;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         online <= 1'b0;
      end else if (wr_en && wr_addr == REG_CTRL) begin
         online <= wr_data[0];
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         upper <= UPPER_RST;
         lower <= LOWER_RST;
      end else if (link_rise) begin
         upper <= UPPER_RST;
         lower <= LOWER_RST;
      end else if (wr_en && wr_addr == REG_UPPER) begin
         if (wr_data[15:0] > lower && wr_data[15:0] <= RPM_MAX) begin
            upper <= wr_data[15:0];
         end
      end else if (wr_en && wr_addr == REG_LOWER) begin
         if (wr_data[15:0] < upper) begin
            lower <= wr_data[15:0];
         end
      end else if (mode != ST_MEAS) begin
         if (press[K_RIGHT] && lower + STEP_RPM < upper) begin
            lower <= lower + STEP_RPM;
         end else if (press[K_LEFT] && lower >= STEP_RPM) begin
            lower <= lower - STEP_RPM;
         end else if (press[K_UP] && upper + STEP_RPM <= RPM_MAX) begin
            upper <= upper + STEP_RPM;
         end else if (press[K_DOWN] && upper >= STEP_RPM + lower + 16'h1) begin
            upper <= upper - STEP_RPM;
         end
      end
   end

   // the first gate after connection seeds both extremes
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I || link_rise) begin
         min_rpm <= RPM_MAX;
         max_rpm <= '0;
      end else if (online && rpm_stb) begin
         if (rpm < min_rpm) begin
            min_rpm <= rpm;
         end
         if (rpm > max_rpm) begin
            max_rpm <= rpm;
         end
      end
   end

   // ------------------------------------------------------------
   // settings mode
   // ------------------------------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I || !online) begin
         mode <= ST_MEAS;
      end else begin
         unique case (mode)
            ST_MEAS: begin
               if (press[K_CENTER]) begin
                  mode <= ST_SET_LO;
               end
            end
            ST_SET_LO, ST_SET_HI: begin
               if (press[K_CENTER]) begin
                  mode <= ST_MEAS;
               end else if (press[K_UP] || press[K_DOWN]) begin
                  mode <= ST_SET_HI;
               end else if (press[K_LEFT] || press[K_RIGHT]) begin
                  mode <= ST_SET_LO;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // lamps and display
   // ------------------------------------------------------------
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I || !online) begin
         LAMPS_O <= '0;
      end else if (mode == ST_SET_HI) begin
         LAMPS_O <= 3'b110;
      end else if (mode == ST_SET_LO) begin
         LAMPS_O <= 3'b011;
      end else begin
         LAMPS_O.over_alarm_lamp <= rpm > upper;
         LAMPS_O.in_band_lamp <= rpm >= lower && rpm <= upper;
         LAMPS_O.under_alarm_lamp <= rpm < lower;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         DISP_ON_O <= 1'b0;
         DISP_BCD_O <= '0;
      end else begin
         DISP_ON_O <= online;
         if (mode == ST_SET_LO) begin
            DISP_BCD_O <= to_bcd(lower);
         end else if (mode == ST_SET_HI) begin
            DISP_BCD_O <= to_bcd(upper);
         end else if (deb[K_MIN]) begin
            DISP_BCD_O <= to_bcd(min_rpm);
         end else if (deb[K_MAX]) begin
            DISP_BCD_O <= to_bcd(max_rpm);
         end else begin
            DISP_BCD_O <= to_bcd(rpm);
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   logic aw_full, w_full;
   logic [7:0] aw_addr;
   assign wr_en = aw_full && w_full && !BVALID_O;
   assign wr_addr = aw_addr;

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= REG_STATUS;
   endfunction : mapped

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= '0;
         wr_data <= '0;
         AWREADY_O <= 1'b0;
         WREADY_O <= 1'b0;
         BVALID_O <= 1'b0;
         BRESP_O <= RESP_OKAY;
      end else begin
         AWREADY_O <= !aw_full && !(AWVALID_I && AWREADY_O);
         WREADY_O <= !w_full && !(WVALID_I && WREADY_O);
         if (AWVALID_I && AWREADY_O) begin
            aw_full <= 1'b1;
            aw_addr <= AWADDR_I;
         end
         if (WVALID_I && WREADY_O) begin
            w_full <= 1'b1;
            wr_data <= WDATA_I;
         end
         if (wr_en) begin
            BVALID_O <= 1'b1;
            BRESP_O <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            AWREADY_O <= 1'b1;
            WREADY_O <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         ARREADY_O <= 1'b0;
         RVALID_O <= 1'b0;
         RDATA_O <= '0;
         RRESP_O <= RESP_OKAY;
      end else if (ARVALID_I && ARREADY_O) begin
         ARREADY_O <= 1'b0;
         RVALID_O <= 1'b1;
         RRESP_O <= mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
         unique case (ARADDR_I)
            REG_CTRL: RDATA_O <= {31'h0, online};
            REG_RPM: RDATA_O <= {16'h0, rpm};
            REG_MIN: RDATA_O <= {16'h0, min_rpm};
            REG_MAX: RDATA_O <= {16'h0, max_rpm};
            REG_UPPER: RDATA_O <= {16'h0, upper};
            REG_LOWER: RDATA_O <= {16'h0, lower};
            REG_STATUS: RDATA_O <= {27'h0, mode, LAMPS_O};
            default: RDATA_O <= '0;
         endcase
      end else if (RVALID_O && RREADY_I) begin
         RVALID_O <= 1'b0;
         ARREADY_O <= 1'b1;
      end else if (!RVALID_O) begin
         ARREADY_O <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!NRST_I);

   sequence s_meas_view;
      online && mode == ST_MEAS && !link_rise;
   endsequence
   sequence s_centre_in_meas;
      online && mode == ST_MEAS ##0 press[K_CENTER];
   endsequence

   a_thr_order: assert property (upper > lower)
      else $error("upper threshold not above lower");
   a_over_lamp: assert property (s_meas_view ##0 rpm > upper |=> LAMPS_O == 3'b100)
      else $error("over lamp wrong");
   a_in_band: assert property (s_meas_view ##0 rpm >= lower && rpm <= upper
      |=> LAMPS_O == 3'b010)
      else $error("in-band lamp wrong");
   a_under_lamp: assert property (s_meas_view ##0 rpm < lower |=> LAMPS_O == 3'b001)
      else $error("under lamp wrong");
   a_set_hi_lamps: assert property (online && mode == ST_SET_HI |=> LAMPS_O == 3'b110)
      else $error("upper edit lamps wrong");
   a_set_lo_lamps: assert property (online && mode == ST_SET_LO |=> LAMPS_O == 3'b011)
      else $error("lower edit lamps wrong");
   a_link_defaults: assert property (link_rise |=> upper == UPPER_RST && lower == LOWER_RST)
      else $error("defaults not loaded on connection");
   a_disp_gated: assert property (!online |=> !DISP_ON_O)
      else $error("display on while offline");
   a_enter_set: assert property (s_centre_in_meas |=> mode == ST_SET_LO ##1
      DISP_BCD_O == to_bcd($past(lower)))
      else $error("settings entry wrong");
   a_step_right: assert property (online && mode != ST_MEAS && !link_rise && !wr_en
      && press[K_RIGHT] && lower + STEP_RPM < upper |=> lower == $past(lower) + STEP_RPM)
      else $error("right step wrong");
   a_min_track: assert property (online && !link_rise && rpm_stb && rpm < min_rpm
      |=> min_rpm == $past(rpm))
      else $error("minimum not tracked");
endmodule : rpmm_top

// *** verif/rpmm_axi_master.sv ***
// register bus master model standing in for the link master
`timescale 1ns/1ps
module rpmm_axi_master (
   // clock
   input wire logic clk_i,
   // write channels
   output logic [7:0] awaddr_o,
   output logic awvalid_o,
   input wire logic awready_i,
   output logic [31:0] wdata_o,
   output logic wvalid_o,
   input wire logic wready_i,
   input wire logic [1:0] bresp_i,
   input wire logic bvalid_i,
   output logic bready_o,
   // read channels
   output logic [7:0] araddr_o,
   output logic arvalid_o,
   input wire logic arready_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i,
   input wire logic rvalid_i,
   output logic rready_o
);
   initial begin
      awaddr_o = 8'h00;
      awvalid_o = 1'b0;
      wdata_o = 32'h0;
      wvalid_o = 1'b0;
      bready_o = 1'b0;
      araddr_o = 8'h00;
      arvalid_o = 1'b0;
      rready_o = 1'b0;
   end
   // -----------------------------------------------------------
   // transfers: the device never speaks first
   // -----------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      @(posedge clk_i);
      awaddr_o <= a;
      awvalid_o <= 1'b1;
      wdata_o <= d;
      wvalid_o <= 1'b1;
      bready_o <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awready_i) awvalid_o <= 1'b0;
         if (wready_i) wvalid_o <= 1'b0;
      end while (!bvalid_i);
      resp = bresp_i;
      bready_o <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge clk_i);
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arready_i) arvalid_o <= 1'b0;
      end while (!rvalid_i);
      d = rdata_i;
      resp = rresp_i;
      rready_o <= 1'b0;
   endtask : rd
endmodule : rpmm_axi_master

// *** verif/rpmm_top_tb.sv ***
// self-checking bench of the rpm threshold monitor
`timescale 1ns/1ps
module rpmm_top_tb;
   import rpmm_pkg::*;
   localparam int GATE = 200;
   localparam int DEB = 4;
   logic clk;
   logic nrst;
   logic mag;
   rpmm_keys_t keys;
   rpmm_lamps_t lamps;
   logic [15:0] disp;
   logic disp_on;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd_v;
   logic [1:0] bresp, rresp, rsp;
   int num_errors = 0;
   int check_count = 0;
   int per = 0;
   int ph = 0;
   int up, lo, mode, rpm, mn, mx;
   int pt[7] = '{5, 10, 20, 40, 50, 100, 200};
   int seq[18] = '{K_CENTER, K_RIGHT, K_RIGHT, K_RIGHT, K_LEFT, K_LEFT, K_LEFT, K_LEFT,
      K_LEFT, K_UP, K_DOWN, K_DOWN, K_DOWN, K_DOWN, K_DOWN, K_DOWN, K_RIGHT, K_CENTER};

   rpmm_top #(.MAGNETS(1), .GATE_CYCLES(GATE), .DEB_CYCLES(DEB)) i_rpmm_top (
      .CLOCK_I(clk), .NRST_I(nrst), .MAG_PULSE_I(mag), .KEYS_I(keys), .LAMPS_O(lamps),
      .DISP_BCD_O(disp), .DISP_ON_O(disp_on), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
      .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));
   rpmm_axi_master i_rpmm_axi_master (
      .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
      .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
      .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
      .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
      .rready_o(rready));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // strictly periodic pulses: a gate that is a multiple of the period counts exactly
   initial begin
      mag = 1'b0;
      forever begin
         @(posedge clk);
         ph = (per == 0) ? 0 : (ph + 1) % per;
         mag <= (per != 0) && (ph < 2);
      end
   end
   // -----------------------------------------------------------
   // checking helpers
   // -----------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   function automatic logic [15:0] bcd(input int v);
      return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction : bcd
   function automatic logic [2:0] exp_lamps();
      if (mode == 1) return 3'b011;
      if (mode == 2) return 3'b110;
      if (rpm > up) return 3'b100;
      if (rpm < lo) return 3'b001;
      return 3'b010;
   endfunction : exp_lamps
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      i_rpmm_axi_master.rd(a, rd_v, rsp);
      chk("rdata", rd_v, e);
      chk("rresp", {30'h0, rsp}, {30'h0, er});
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      i_rpmm_axi_master.wr(a, d, rsp);
      chk("bresp", {30'h0, rsp}, {30'h0, er});
   endtask : wr
   task automatic verify();
      rd(REG_UPPER, 32'(up));
      rd(REG_LOWER, 32'(lo));
      rd(REG_STATUS, {27'h0, 2'(mode), exp_lamps()});
      chk("lamps", {29'h0, lamps}, {29'h0, exp_lamps()});
      chk("display", {16'h0, disp}, {16'h0, bcd(mode == 1 ? lo : mode == 2 ? up : rpm)});
   endtask : verify
   task automatic press(input int k);
      int b;
      b = $urandom_range(3, 0);
      // chatter shorter than the debounce time must not count
      repeat (b) begin
         @(posedge clk);
         keys <= rpmm_keys_t'(7'(1 << k));
         @(posedge clk);
         keys <= '0;
      end
      @(posedge clk);
      keys <= rpmm_keys_t'(7'(1 << k));
      repeat (DEB + 8) @(posedge clk);
      keys <= '0;
      repeat (DEB + 8) @(posedge clk);
      case (k)
         K_CENTER: mode = (mode == 0) ? 1 : 0;
         K_RIGHT: if (mode != 0) begin
            mode = 1;
            if (lo + 100 < up) lo += 100;
         end
         K_LEFT: if (mode != 0) begin
            mode = 1;
            if (lo >= 100) lo -= 100;
         end
         K_UP: if (mode != 0) begin
            mode = 2;
            if (up + 100 <= 9999) up += 100;
         end
         K_DOWN: if (mode != 0) begin
            mode = 2;
            if (up - 100 > lo) up -= 100;
         end
         default: ;
      endcase
   endtask : press
   task automatic set_rate(input int p);
      per = p;
      repeat (3 * GATE) @(posedge clk);
      rpm = (GATE / p) * 60;
      if (rpm < mn) mn = rpm;
      if (rpm > mx) mx = rpm;
      rd(REG_RPM, 32'(rpm));
      verify();
   endtask : set_rate
   task automatic finish_test();
      if (num_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      void'($urandom(32'hF89E));
      nrst = 1'b0;
      keys = '0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      chk("disp_on", {31'h0, disp_on}, 32'h0);
      chk("lamps", {29'h0, lamps}, 32'h0);
      per = 20;
      repeat (GATE + 50) @(posedge clk);
      rd(REG_CTRL, 32'h0);
      wr(REG_CTRL, 32'h1);
      up = 500;
      lo = 200;
      mode = 0;
      rpm = 600;
      mn = 600;
      mx = 600;
      repeat (2 * GATE + 20) @(posedge clk);
      chk("disp_on", {31'h0, disp_on}, 32'h1);
      verify();
      set_rate(40);
      set_rate(100);
      set_rate(pt[$urandom_range(6, 0)]);
      set_rate(pt[$urandom_range(6, 0)]);
      rd(REG_MIN, 32'(mn));
      rd(REG_MAX, 32'(mx));
      keys <= rpmm_keys_t'(7'(1 << K_MIN));
      repeat (DEB + 8) @(posedge clk);
      chk("min view", {16'h0, disp}, {16'h0, bcd(mn)});
      keys <= rpmm_keys_t'(7'(1 << K_MAX));
      repeat (DEB + 8) @(posedge clk);
      chk("max view", {16'h0, disp}, {16'h0, bcd(mx)});
      keys <= '0;
      set_rate(40);
      foreach (seq[i]) begin
         press(seq[i]);
         verify();
      end
      // refused writes still answer okay and leave the value alone
      wr(REG_UPPER, 32'd800);
      up = 800;
      wr(REG_LOWER, 32'd900);
      wr(REG_UPPER, 32'd0);
      wr(REG_UPPER, 32'd10000);
      wr(REG_LOWER, 32'd250);
      lo = 250;
      wr(REG_RPM, 32'h1234);
      rd(REG_RPM, 32'(rpm));
      wr(8'h02, 32'h0, RESP_SLVERR);
      rd(8'h1C, 32'h0, RESP_SLVERR);
      verify();
      wr(REG_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      chk("disp_on", {31'h0, disp_on}, 32'h0);
      chk("lamps", {29'h0, lamps}, 32'h0);
      wr(REG_CTRL, 32'h1);
      up = 500;
      lo = 200;
      repeat (3) @(posedge clk);
      verify();
      // extremes restart with the new connection, so one gate seeds both
      mn = rpm;
      mx = rpm;
      repeat (GATE + 10) @(posedge clk);
      rd(REG_MIN, 32'(mn));
      rd(REG_MAX, 32'(mx));
      finish_test();
   end
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      finish_test();
   end
endmodule : rpmm_top_tb
